// *** hw/flash_host_pkg.sv ***
// Constants for the parallel flash host controller: timing and command codes.
// Assumes a 50 MHz system clock and an asynchronous x16 flash on the pins.
// Contract
// (R1) Device is active while select is low and reset_powerdown_n high.
// (R2) Idle reads drop to auto_power_saving with outputs kept valid.
// (R3) Select high means standby and data pins released.
// (R4) Program or erase continues to completion after deselect.
// (R5) reset_powerdown_n low puts the device in deep power-down.
// (R6) reset_powerdown_n falling during read deselects and floats outputs.
// (R7) Host waits read or write recovery time after raising reset_powerdown_n.
// (R8) reset_powerdown_n falling aborts program or erase; target left undefined.
// (R9) Status register clears when reset_powerdown_n goes low or power drops.
// (R10) Host holds reset_powerdown_n low while supplies ramp.
// (R11) A write needs both select and write strobe low.
// (R12) Array changes only after a full two-cycle command sequence.
// (R13) Device ignores controls while reset_powerdown_n is low.
// (R14) Host drives reset_powerdown_n from processor reset.
// (R15) Small-geometry word program ends within 200 us, typically 12 us.
// (R16) Largest-geometry word program ends within 200 us, typically 22 us.
// (R17) Host keeps device in reset through power-up and power-down.
// (R18) Leaving reset: array-read mode, status 0x80, all blocks locked.
// (R19) Address and data latched on first rising edge of strobe or select.
// (R20) Host flags word program failed after the maximum program time.
package flash_host_pkg;
	localparam int unsigned CLK_MHZ             = 50;
	localparam int unsigned READ_RECOVERY_NS    = 150;
	localparam int unsigned WRITE_RECOVERY_NS   = 150;
	localparam int unsigned WRITE_PULSE_NS      = 60;
	localparam int unsigned WRITE_HIGH_NS       = 30;
	localparam int unsigned READ_ACCESS_NS      = 80;
	localparam int unsigned RESET_LOW_NS        = 100;
	localparam int unsigned WORD_PROGRAM_MAX_US = 200;
	localparam int unsigned POLL_GAP_NS         = 60;
	// Least times round up to whole cycles
	localparam int unsigned READ_RECOVERY_CYC   = (READ_RECOVERY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WRITE_RECOVERY_CYC  = (WRITE_RECOVERY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WRITE_PULSE_CYC     = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WRITE_HIGH_CYC      = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned READ_ACCESS_CYC     = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RESET_LOW_CYC       = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned POLL_GAP_CYC        = (POLL_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WORD_PROGRAM_CYC    = WORD_PROGRAM_MAX_US * CLK_MHZ;
	localparam logic [15:0] CMD_PROGRAM         = 16'h0040;
	localparam logic [15:0] CMD_READ_ARRAY      = 16'h00ff;
	localparam logic [15:0] CMD_READ_STATUS     = 16'h0070;
	localparam logic [15:0] CMD_CLEAR_STATUS    = 16'h0050;
	localparam logic [15:0] STATUS_READY        = 16'h0080;
	localparam int unsigned STATUS_READY_BIT    = 7;
	localparam logic [7:0]  STATUS_ERR_MASK     = 8'h1a;
	typedef enum logic [3:0] {
		ST_PWRDN  = 4'h0,
		ST_RECOV  = 4'h1,
		ST_IDLE   = 4'h2,
		ST_READ   = 4'h3,
		ST_WLOW   = 4'h4,
		ST_WHIGH  = 4'h5,
		ST_POLL   = 4'h6,
		ST_PGAP   = 4'h7,
		ST_DONE   = 4'h8
	} state_t;
endpackage

// *** hw/cycle_timer.sv ***
// Down-counting delay timer used for every state wait of the flash host; the program watchdog has its own counter.
// Same clock as its user; load is a single-cycle level term, expiry a level held until the next load.
`timescale 1ns/1ps
module cycle_timer #(
	parameter int unsigned WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output logic                  expired
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// A load wins over counting so a fresh wait always starts clean
	assign cnt_d   = load ? count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
	// Expiry looks at the register only: the user loads on expiry, so a load term here would loop
	assign expired = (cnt_q == '0);

	// Counter register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule

// *** hw/flash_host.sv ***
// Host controller for an asynchronous parallel NOR flash: reads, word program, power-down.
// User side is a single-request handshake; flash pins are driven from flops.
`timescale 1ns/1ps
module flash_host #(
	parameter int unsigned ADDR_W      = 22,
	parameter int unsigned PROG_CYCLES = flash_host_pkg::WORD_PROGRAM_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [15:0]       req_wdata,
	output logic                   rsp_valid,
	output logic [15:0]            rsp_rdata,
	output logic                   rsp_error,
	input  wire logic              powerdown,
	output logic                   reset_powerdown_n,
	output logic                   chip_select_n,
	output logic                   output_enable_n,
	output logic                   write_strobe_n,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [15:0]            dq_out,
	output logic                   dq_oe,
	input  wire logic [15:0]       dq_in
);
	localparam int unsigned TW = 24;
	flash_host_pkg::state_t state_q;
	flash_host_pkg::state_t state_d;
	logic [15:0]       dq_s1_q;
	logic [15:0]       dq_s2_q;
	logic              step_q;
	logic              rpn_q;
	logic              cs_n_q;
	logic              oe_n_q;
	logic              we_n_q;
	logic              dq_oe_q;
	logic [ADDR_W-1:0] addr_q;
	logic [15:0]       dout_q;
	logic [15:0]       wdata_q;
	logic [15:0]       rdata_q;
	logic              err_q;
	logic              rsp_q;
	logic [TW-1:0]     guard_q;
	logic              tmr_load;
	logic [TW-1:0]     tmr_count;
	logic              tmr_done;
	logic              take;
	logic              ready_bit;
	logic              guard_out;
	logic              stat_err;

	// Pin data crosses from the flash, so it is synchronised before use
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end
		else
		begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	cycle_timer #(.WIDTH(TW)) u_timer (
		.clk     (clk),
		.rst     (rst),
		.load    (tmr_load),
		.count   (tmr_count),
		.expired (tmr_done)
	);

	// Request accepted only in idle and when not asked to power down
	assign req_ready = (state_q == flash_host_pkg::ST_IDLE) && !powerdown;
	assign take      = req_valid && req_ready;
	assign ready_bit = dq_s2_q[flash_host_pkg::STATUS_READY_BIT];
	assign stat_err  = (dq_s2_q[7:0] & flash_host_pkg::STATUS_ERR_MASK) != 8'h00;
	assign guard_out = (guard_q == '0);

	// Sequencer; reset_powerdown_n is held low in reset so supply ramps stay masked
	always_comb
	begin
		state_d   = state_q;
		tmr_load  = 1'b0;
		tmr_count = '0;
		unique case (state_q)
			flash_host_pkg::ST_PWRDN:
				if (!powerdown && tmr_done)                                  // [R10] [R17]
				begin
					state_d   = flash_host_pkg::ST_RECOV;
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::WRITE_RECOVERY_CYC > flash_host_pkg::READ_RECOVERY_CYC ?
						flash_host_pkg::WRITE_RECOVERY_CYC : flash_host_pkg::READ_RECOVERY_CYC); // [R7]
				end
			flash_host_pkg::ST_RECOV:
				if (tmr_done)
					state_d = flash_host_pkg::ST_IDLE;                           // [R7]
			flash_host_pkg::ST_IDLE:
				if (powerdown)
				begin
					state_d   = flash_host_pkg::ST_PWRDN;                        // [R5]
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::RESET_LOW_CYC);
				end
				else if (take && req_write)
				begin
					state_d   = flash_host_pkg::ST_WLOW;
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::WRITE_PULSE_CYC);
				end
				else if (take)
				begin
					state_d   = flash_host_pkg::ST_READ;
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::READ_ACCESS_CYC + 2);   // Two extra for the synchroniser
				end
			flash_host_pkg::ST_READ:
				if (tmr_done)
					state_d = flash_host_pkg::ST_DONE;
			flash_host_pkg::ST_WLOW:
				if (tmr_done)
				begin
					state_d   = flash_host_pkg::ST_WHIGH;                        // [R19]
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::WRITE_HIGH_CYC);
				end
			flash_host_pkg::ST_WHIGH:
				if (tmr_done && !step_q)
				begin
					state_d   = flash_host_pkg::ST_WLOW;                         // [R12]
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::WRITE_PULSE_CYC);
				end
				else if (tmr_done)
				begin
					state_d   = flash_host_pkg::ST_POLL;
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::READ_ACCESS_CYC + 2);
				end
			flash_host_pkg::ST_POLL:
				if (tmr_done && (ready_bit || guard_out))
					state_d = flash_host_pkg::ST_DONE;                           // [R15] [R16] [R20]
				else if (tmr_done)
				begin
					state_d   = flash_host_pkg::ST_PGAP;
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::POLL_GAP_CYC);
				end
			flash_host_pkg::ST_PGAP:
				if (tmr_done)
				begin
					state_d   = flash_host_pkg::ST_POLL;
					tmr_load  = 1'b1;
					tmr_count = TW'(flash_host_pkg::READ_ACCESS_CYC + 2);
				end
			flash_host_pkg::ST_DONE:
				state_d = flash_host_pkg::ST_IDLE;
			default:
				state_d = flash_host_pkg::ST_PWRDN;
		endcase
	end

	// State register; reset starts in power-down so the flash follows system reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= flash_host_pkg::ST_PWRDN;                                 // [R14]
		else
			state_q <= state_d;
	end

	// Pin drive: select and strobe low together only for a write pulse
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rpn_q   <= 1'b0;
			cs_n_q  <= 1'b1;
			oe_n_q  <= 1'b1;
			we_n_q  <= 1'b1;
			dq_oe_q <= 1'b0;
		end
		else
		begin
			rpn_q   <= (state_d != flash_host_pkg::ST_PWRDN);                    // [R5] [R13]
			cs_n_q  <= !(state_d inside {flash_host_pkg::ST_READ, flash_host_pkg::ST_WLOW,
				flash_host_pkg::ST_POLL});                                           // [R3] [R1]
			oe_n_q  <= !(state_d inside {flash_host_pkg::ST_READ, flash_host_pkg::ST_POLL});
			we_n_q  <= (state_d != flash_host_pkg::ST_WLOW);                      // [R11]
			dq_oe_q <= (state_d inside {flash_host_pkg::ST_WLOW, flash_host_pkg::ST_WHIGH});
		end
	end

	// Address, write data and command step; the first pulse is the program setup
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			addr_q  <= '0;
			dout_q  <= 16'h0000;
			wdata_q <= 16'h0000;
			step_q  <= 1'b0;
		end
		else if (take)
		begin
			addr_q  <= req_addr;
			wdata_q <= req_wdata;
			dout_q  <= req_write ? flash_host_pkg::CMD_PROGRAM : flash_host_pkg::CMD_READ_ARRAY;
			step_q  <= 1'b0;
		end
		else if (state_q == flash_host_pkg::ST_WHIGH && state_d == flash_host_pkg::ST_WLOW)
		begin
			dout_q <= wdata_q;                                                    // [R12]
			step_q <= 1'b1;
		end
	end

	// Program watchdog: counts from the move into polling, after the high time that follows the second strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			guard_q <= '0;
		else if (state_q == flash_host_pkg::ST_WHIGH && state_d == flash_host_pkg::ST_POLL)
			guard_q <= TW'(PROG_CYCLES);                                         // [R20]
		else if (!guard_out)
			guard_q <= guard_q - 1'b1;
	end

	// Response capture; a timeout or status error bit marks the program failed
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 16'h0000;
			err_q   <= 1'b0;
			rsp_q   <= 1'b0;
		end
		else
		begin
			rsp_q <= (state_d == flash_host_pkg::ST_DONE);
			if (state_d == flash_host_pkg::ST_DONE)
			begin
				rdata_q <= dq_s2_q;
				err_q   <= (state_q == flash_host_pkg::ST_POLL) && (!ready_bit || stat_err); // [R20]
			end
		end
	end

	assign reset_powerdown_n = rpn_q;
	assign chip_select_n     = cs_n_q;
	assign output_enable_n   = oe_n_q;
	assign write_strobe_n    = we_n_q;
	assign flash_addr        = addr_q;
	assign dq_out            = dout_q;
	assign dq_oe             = dq_oe_q;
	assign rsp_valid         = rsp_q;
	assign rsp_rdata         = rdata_q;
	assign rsp_error         = err_q;

	// Recovery count seen from the host pins
	logic [7:0] rec_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rec_q <= 8'h00;
		else if (!rpn_q)
			rec_q <= 8'h00;
		else if (rec_q != 8'hff)
			rec_q <= rec_q + 8'h01;
	end

	recovery_wait_a: assert property (@(posedge clk) disable iff (rst) // [R7]
		$fell(chip_select_n) |-> rec_q >= 8'(flash_host_pkg::READ_RECOVERY_CYC))
		else $error("access started inside recovery time");
	write_gating_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		!write_strobe_n |-> !chip_select_n && output_enable_n && dq_oe)
		else $error("write strobe without select or with output enable");
	powerdown_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		!reset_powerdown_n |-> chip_select_n && write_strobe_n && !dq_oe)
		else $error("controls active during power-down");
	bus_contention_a: assert property (@(posedge clk) disable iff (rst) // [R3]
		!(dq_oe && !output_enable_n))
		else $error("host drives data while flash outputs enabled");
	two_cycle_a: assert property (@(posedge clk) disable iff (rst) // [R12]
		$fell(write_strobe_n) && dq_out != flash_host_pkg::CMD_PROGRAM |-> $past(step_q) == 1'b0 ##0 step_q)
		else $error("data write without setup cycle");
	reset_low_a: assert property (@(posedge clk) disable iff (rst) // [R5]
		$fell(reset_powerdown_n) |-> !reset_powerdown_n [*5])
		else $error("reset_powerdown_n low pulse too short");
	timeout_error_a: assert property (@(posedge clk) disable iff (rst) // [R20]
		state_q == flash_host_pkg::ST_POLL && guard_out && tmr_done && !ready_bit |=> rsp_valid && rsp_error)
		else $error("program timeout not reported");
	pulse_width_a: assert property (@(posedge clk) disable iff (rst) // [R19]
		$fell(write_strobe_n) |-> !write_strobe_n [*3])
		else $error("write pulse too short");
	read_cover: cover property (@(posedge clk) disable iff (rst) take && !req_write);
	prog_cover: cover property (@(posedge clk) disable iff (rst) rsp_valid && !rsp_error && step_q);
	fail_cover: cover property (@(posedge clk) disable iff (rst) rsp_valid && rsp_error);
	pd_cover:   cover property (@(posedge clk) disable iff (rst) $rose(reset_powerdown_n));
endmodule

// *** bench/flash_model.sv ***
// Behavioural x16 NOR flash seen from its pins: array, program command pair, status, power-down.
// Assumes the host's registered pins and a shared clk that times the internal program, the write capture and the released-bus pattern.
`timescale 1ns/1ps
module flash_model #(
	parameter int unsigned ADDR_W = 22
) (
	input  wire logic              clk,
	input  wire logic              reset_powerdown_n,
	input  wire logic              chip_select_n,
	input  wire logic              output_enable_n,
	input  wire logic              write_strobe_n,
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic [15:0]       dq_out,
	input  wire logic              dq_oe,
	input  wire logic [31:0]       busy_cycles,
	output logic [15:0]            dq_bus,
	output logic                   timing_err
);
	logic [15:0]       mem [logic [ADDR_W-1:0]];
	logic [15:0]       status_q = 16'h0000;
	logic              status_mode = 1'b0;
	logic              armed = 1'b0;
	int                busy = 0;
	logic [ADDR_W-1:0] wa_q, pa_q;
	logic [15:0]       wd_q, pd_q;
	logic [15:0]       float_q = 16'h5a5a;
	realtime           t_rise = 0.0;
	wire               wr_n  = chip_select_n | write_strobe_n;
	wire               drive = reset_powerdown_n & ~chip_select_n & ~output_enable_n;
	wire [15:0]        dout  = status_mode ? status_q : (mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff);

	// Released bus never shows the last value, so a late host sample cannot pass by luck
	assign dq_bus = drive ? dout : (dq_oe ? dq_out : float_q);
	initial timing_err = 1'b0;

	// Capture the latest address and data while the write is open
	always @(negedge clk)
		if (!wr_n)
		begin
			wa_q <= flash_addr;
			wd_q <= dq_out;
		end

	// Commands take effect at the first rising edge of strobe or select
	always @(posedge wr_n)
		if (reset_powerdown_n && busy == 0)
		begin
			if (armed)
			begin
				armed = 1'b0;
				pa_q = wa_q;
				pd_q = wd_q;
				busy = busy_cycles;
				status_q = 16'h0000;
			end
			else if (wd_q == 16'h0040)
			begin
				armed = 1'b1;
				status_mode = 1'b1;
			end
			else
				status_mode = (wd_q != 16'h00ff);
		end

	// Program finishes on its own, selected or not
	always @(posedge clk)
	begin
		float_q <= ~float_q;
		if (busy > 0)
		begin
			busy = busy - 1;
			if (busy == 0)
			begin
				mem[pa_q] = pd_q;
				status_q = 16'h0080;
			end
		end
		if (dq_oe && drive)
			timing_err = 1'b1;
	end

	// Power-down aborts and clears; wake-up restores array reads
	always @(negedge reset_powerdown_n)
	begin
		if (busy > 0)
			mem[pa_q] = ~pd_q;
		busy = 0;
		armed = 1'b0;
		status_q = 16'h0000;
	end
	always @(posedge reset_powerdown_n)
	begin
		t_rise = $realtime;
		status_q = 16'h0080;
		status_mode = 1'b0;
	end

	// Host must let the recovery time run out before any access
	always @(negedge chip_select_n or negedge write_strobe_n)
		if (reset_powerdown_n && ($realtime - t_rise) < 150.0)
			timing_err = 1'b1;
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for flash_host against the behavioural flash model.
// Assumes the design and package are compiled first; program timeout shortened to 200 cycles.
`timescale 1ns/1ps
module testbench;
	localparam int unsigned AW = 22;
	localparam int unsigned PC = 200;
	logic          clk, rst, req_valid, req_write, powerdown;
	logic [AW-1:0] req_addr, a;
	logic [15:0]   req_wdata, d, rdata_s, dq_out, dq_bus, rsp_rdata;
	logic          req_ready, rsp_valid, rsp_error, err_s, dq_oe, timing_err;
	logic          reset_powerdown_n, chip_select_n, output_enable_n, write_strobe_n;
	logic [AW-1:0] flash_addr;
	logic [31:0]   busy_cycles;
	logic [15:0]   shadow [logic [AW-1:0]];
	int            mismatches, comparisons, seed, i;

	flash_host #(.ADDR_W(AW), .PROG_CYCLES(PC)) u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .powerdown(powerdown),
		.reset_powerdown_n(reset_powerdown_n), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
		.write_strobe_n(write_strobe_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus));
	flash_model #(.ADDR_W(AW)) u_flash (.clk(clk), .reset_powerdown_n(reset_powerdown_n),
		.chip_select_n(chip_select_n), .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
		.flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .busy_cycles(busy_cycles),
		.dq_bus(dq_bus), .timing_err(timing_err));

	// Free-running 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Array content expected after a wake-up
	function automatic logic [15:0] exp_read(input logic [AW-1:0] ad);
		return shadow.exists(ad) ? shadow[ad] : 16'hffff;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One request: wait for ready, hold one taking edge, then wait for the answer pulse
	task automatic do_req(input logic w, input logic [AW-1:0] ad, input logic [15:0] wd);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 50)
		begin
			mismatches++;
			$display("[FAIL] %0t request never accepted", $time);
		end
		req_valid = 1'b1;
		req_write = w;
		req_addr = ad;
		req_wdata = wd;
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < PC + 400)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= PC + 400)
		begin
			mismatches++;
			$display("[FAIL] %0t no answer to request", $time);
		end
		rdata_s = rsp_rdata;
		err_s = rsp_error;
	endtask

	// Deep power-down and wake; host must deselect and refuse while asleep
	task automatic pd_cycle();
		@(negedge clk);
		powerdown = 1'b1;
		repeat (4) @(negedge clk);
		check({15'h0000, reset_powerdown_n}, 16'h0000);
		check({15'h0000, chip_select_n}, 16'h0001);
		check({15'h0000, req_ready}, 16'h0000);
		repeat (4) @(negedge clk);
		powerdown = 1'b0;
	endtask

	initial
	begin
		#1_000_000;
		mismatches++;
		$display("[FAIL] %0t watchdog ran out", $time);
		test_done();
	end

	initial
	begin
		seed = 32'h12de_fb35;
		{rst, req_valid, req_write, powerdown} = 4'b1000;
		req_addr = '0;
		req_wdata = 16'h0000;
		busy_cycles = 32'h0000_0014;
		mismatches = 0;
		comparisons = 0;
		repeat (4) @(posedge clk);
		check({15'h0000, reset_powerdown_n}, 16'h0000);
		@(negedge clk);
		rst = 1'b0;
		// Program, wake to array mode, read back; corners at both address ends
		for (i = 0; i < 6; i++)
		begin
			a = (i == 0) ? '0 : (i == 1) ? '1 : AW'($random(seed) & 32'h0000_000f);
			d = 16'($random(seed));
			do_req(1'b1, a, d);
			check({15'h0000, err_s}, 16'h0000);
			check(rdata_s, flash_host_pkg::STATUS_READY);
			shadow[a] = d;
			pd_cycle();
			do_req(1'b0, a, 16'h0000);
			check(rdata_s, exp_read(a));
			check({15'h0000, err_s}, 16'h0000);
			do_req(1'b0, a ^ AW'(32'h0000_0100), 16'h0000);
			check(rdata_s, exp_read(a ^ AW'(32'h0000_0100)));
		end
		// Program that never completes must be reported, then aborted by power-down
		busy_cycles = PC + 300;
		do_req(1'b1, 22'h00_0033, 16'h1234);
		check({15'h0000, err_s}, 16'h0001);
		pd_cycle();
		busy_cycles = 32'h0000_0014;
		do_req(1'b1, 22'h00_0034, 16'hbeef);
		check({15'h0000, err_s}, 16'h0000);
		check(rdata_s, flash_host_pkg::STATUS_READY);
		// The aborted word must not read back as if the program had finished
		pd_cycle();
		do_req(1'b0, 22'h00_0033, 16'h0000);
		check({15'h0000, rdata_s == 16'h1234}, 16'h0000);
		check({15'h0000, timing_err}, 16'h0000);
		test_done();
	end
endmodule
